// ===== core/mcs_machining_cycle_sequencer.sv
// one machining cycle: descend, advance, slow feed, retract, rapid return
`timescale 1ns/1ns
`default_nettype none
// Contract
// - A start request switches on the belt drive and lowers the arm.
// - The arm slot sensor ends the descent and starts the cross-slide toward the work.
// - The tool contact sensor stops the cross-slide and starts the slow carriage feed.
// - Slow feed runs until the feed end sensor, then the cross-slide retracts quickly.
// - Fast retraction runs until the retract end sensor, then the carriage returns rapidly.
// - Rapid return runs until the home position sensor, which completes the cycle.
// - With auto repeat set, reaching home starts the next cycle at once.
module mcs_machining_cycle_sequencer (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // operator controls, asynchronous pins
  input  wire logic startButton,
  input  wire logic autoRepeat,
  // position sensors, asynchronous pins, high when the vane is in the slot
  input  wire logic armSlotSensor,
  input  wire logic toolContactSensor,
  input  wire logic feedEndSensor,
  input  wire logic retractEndSensor,
  input  wire logic homePositionSensor,
  // motor contactors
  output logic      beltDrive,
  output logic      armDescend,
  output logic      slideAdvance,
  output logic      carriageSlowFeed,
  output logic      slideRetractFast,
  output logic      carriageReturnFast,
  // status
  output logic      cycleDone
);

  // two-stage synchronisers; stage one is read only by stage two
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic       startPrev;
  logic       startEdge;
  mcs_pkg::mcs_step_e step;
  mcs_pkg::mcs_step_e next_step;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 7'h00;
      syncB <= 7'h00;
    end else begin
      syncA <= {autoRepeat, startButton, armSlotSensor, toolContactSensor,
                feedEndSensor, retractEndSensor, homePositionSensor};
      syncB <= syncA;
    end
  end

  // edge on the button so a held button cannot restart after completion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      startPrev <= 1'b0;
    end else begin
      startPrev <= syncB[5];
    end
  end

  assign startEdge = syncB[5] & ~startPrev;

  always_comb begin
    next_step = step;
    unique case (step)
      mcs_pkg::MCS_IDLE:    if (startEdge) next_step = mcs_pkg::MCS_DESCEND;
      mcs_pkg::MCS_DESCEND: if (syncB[4]) next_step = mcs_pkg::MCS_ADVANCE;
      mcs_pkg::MCS_ADVANCE: if (syncB[3]) next_step = mcs_pkg::MCS_FEED;
      mcs_pkg::MCS_FEED:    if (syncB[2]) next_step = mcs_pkg::MCS_RETRACT;
      mcs_pkg::MCS_RETRACT: if (syncB[1]) next_step = mcs_pkg::MCS_RETURN;
      mcs_pkg::MCS_RETURN: begin
        // home ends the cycle; auto repeat treats it as a fresh start
        if (syncB[0]) next_step = syncB[6] ? mcs_pkg::MCS_DESCEND
                                           : mcs_pkg::MCS_IDLE;
      end
      default:              next_step = mcs_pkg::MCS_IDLE;
    endcase
  end

  // only the sensor of the active step is looked at
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step <= mcs_pkg::MCS_IDLE;
    end else begin
      step <= next_step;
    end
  end

  // contactors registered from the next step so they follow the step in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      beltDrive          <= 1'b0;
      armDescend         <= 1'b0;
      slideAdvance       <= 1'b0;
      carriageSlowFeed   <= 1'b0;
      slideRetractFast   <= 1'b0;
      carriageReturnFast <= 1'b0;
    end else begin
      // belt keeps driving the armature for the whole cycle
      beltDrive          <= (next_step != mcs_pkg::MCS_IDLE);
      armDescend         <= (next_step == mcs_pkg::MCS_DESCEND);
      slideAdvance       <= (next_step == mcs_pkg::MCS_ADVANCE);
      carriageSlowFeed   <= (next_step == mcs_pkg::MCS_FEED);
      slideRetractFast   <= (next_step == mcs_pkg::MCS_RETRACT);
      carriageReturnFast <= (next_step == mcs_pkg::MCS_RETURN);
    end
  end

  // one-cycle pulse when the carriage reaches home
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycleDone <= 1'b0;
    end else begin
      cycleDone <= (step == mcs_pkg::MCS_RETURN) && syncB[0];
    end
  end

endmodule
`default_nettype wire

// ===== core/mcs_consts.svh
// constants for the machining cycle sequencer
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH
`define MCS_STATE_W 3
`endif

// ===== core/mcs_pkg.sv
// types for the machining cycle sequencer
`include "mcs_consts.svh"
package mcs_pkg;
  typedef enum logic [`MCS_STATE_W-1:0] {
    MCS_IDLE    = 3'h0,
    MCS_DESCEND = 3'h1,
    MCS_ADVANCE = 3'h2,
    MCS_FEED    = 3'h3,
    MCS_RETRACT = 3'h4,
    MCS_RETURN  = 3'h5
  } mcs_step_e;
endpackage

// ===== sim/mcs_cycle_checker.sv
// port assertions for the cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module mcs_cycle_checker (input wire logic ref_clk, rst_n, beltDrive, cycleDone,
  feedEndSensor, armDescend, slideAdvance, carriageSlowFeed, slideRetractFast,
  carriageReturnFast);
  wire logic [4:0] st = {carriageReturnFast, slideRetractFast, carriageSlowFeed,
    slideAdvance, armDescend};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_feedQuiet; (carriageSlowFeed && !feedEndSensor) [*4]; endsequence
  a_one_step: assert property ($onehot0(st)) else $error("steps");
  a_belt_on: assert property (beltDrive == |st) else $error("belt");
  a_arm_end: assert property ($fell(armDescend) |-> slideAdvance) else $error("arm");
  a_slide_end: assert property ($fell(slideAdvance) |-> carriageSlowFeed)
    else $error("slide");
  a_feed_holds: assert property (s_feedQuiet |=> carriageSlowFeed) else $error("feed");
  a_retract_end: assert property ($fell(slideRetractFast) |-> carriageReturnFast)
    else $error("back");
  a_home_done: assert property ($fell(carriageReturnFast) |-> cycleDone)
    else $error("home");
  a_done_pulse: assert property (cycleDone |=> !cycleDone) else $error("pulse");
endmodule
bind mcs_machining_cycle_sequencer mcs_cycle_checker u_chk (.*);
`default_nettype wire

// ===== sim/mcs_plant.sv
// machine model: a sensor answers once its motion has run a while
`timescale 1ns/1ns
`default_nettype none
module mcs_plant (input wire logic ref_clk, input wire logic [4:0] drive,
  output logic [4:0] sense);
  logic [4:0] last = 5'h00;
  logic [3:0] run = 4'h0;
  // a sensor falls as its motion stops; a fresh motion must run a while before its sensor answers
  always_ff @(posedge ref_clk) begin
    last <= drive;
    run <= (drive != last) ? 4'h0 : ((run == 4'hF) ? run : run + 4'h1);
    sense <= ((run > 4'h5) && (drive == last)) ? drive : 5'h00;
  end
endmodule
`default_nettype wire

// ===== sim/mcs_machining_cycle_sequencer_tb.sv
// bench for the machining cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module mcs_machining_cycle_sequencer_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, startButton = 1'b0, autoRepeat = 1'b0, beltDrive, cycleDone;
  logic [4:0] m, sense, inj = 5'h00;
  int err_total = 0, checks = 0;
  wire logic [4:0] s = sense | inj;
  wire logic [5:0] o = {beltDrive, m};
  initial forever #5 ref_clk = ~ref_clk;
  mcs_plant plant (.ref_clk, .drive(m), .sense);
  mcs_machining_cycle_sequencer dut (.ref_clk, .rst_n, .startButton, .autoRepeat, .beltDrive,
    .armSlotSensor(s[0]), .toolContactSensor(s[1]), .feedEndSensor(s[2]), .cycleDone,
    .retractEndSensor(s[3]), .homePositionSensor(s[4]), .armDescend(m[0]), .slideAdvance(m[1]),
    .carriageSlowFeed(m[2]), .slideRetractFast(m[3]), .carriageReturnFast(m[4]));
  task cyc(input int n); repeat (n) @(posedge ref_clk); #1; endtask
  task chk(input logic [5:0] got, exp);
    checks++;
    if (got !== exp) begin err_total++; $display("[FAIL] %0t %h %h", $time, got, exp); end
  endtask
  task await(input logic [5:0] exp);
    for (int i = 0; i < 99 && o !== exp; i++) cyc(1);
    chk(o, exp);
  endtask
  task t_cycle; // foreign sensors forced while idle and descending; start held
    inj = 5'h1E; cyc(8); chk(o, 6'h00);
    startButton = 1'b1; await(6'h21);
    cyc(3); chk(o, 6'h21); inj = 5'h00;
    for (int k = 1; k < 5; k++) await({1'b1, 5'h01 << k});
    await(6'h00); chk({5'h00, cycleDone}, 6'h01);
    cyc(9); chk(o, 6'h00);
    $display("t_cycle done");
  endtask
  task t_repeat;
    startButton = 1'b0; autoRepeat = 1'b1; cyc(2); startButton = 1'b1;
    await(6'h30); await(6'h21);
    autoRepeat = 1'b0; await(6'h00);
    $display("t_repeat done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(5); rst_n = 1'b1; chk(o, 6'h00);
    t_cycle; t_repeat; finish_test;
  end
  initial begin #20000; err_total++; finish_test; end
endmodule
`default_nettype wire
